// ### mss_pkg.sv
// package: register map, field layout and encodings of the multi-axis sync block
package mss_pkg;
	localparam int          NUM_AXES          = 4;
	localparam logic [11:0] REG_CTRL          = 12'h000;
	localparam logic [11:0] REG_SYNC_OPT      = 12'h004;
	localparam logic [11:0] REG_SYNC_SIG      = 12'h008;
	localparam logic [11:0] REG_CMD           = 12'h00C;
	localparam logic [11:0] REG_STATUS        = 12'h010;
	localparam logic [11:0] REG_BUF_STATUS    = 12'h014;
	// per axis: REG_AXIS_STRIDE (0x20) * axis; above offsets added
	localparam logic [11:0] REG_AXIS_STRIDE   = 12'h020;
	localparam logic [11:0] REG_GLOBAL        = 12'h100;
	localparam int          HW_VER_BIT        = 12;
	localparam logic [31:0] HW_VERSION_RESET  = 32'h0000_1000;
	// global register: bit0 group start, bit1 group stop (write one pulses)
	localparam int          GL_START_BIT      = 0;
	localparam int          GL_STOP_BIT       = 1;
	// ctrl fields
	localparam int          CT_STOP_ON_LINE   = 0;
	localparam int          CT_DRIVE_ON_FAULT = 1;
	localparam int          CT_STOP_MODE      = 2;
	localparam int          CT_CONTI          = 3;
	localparam int          CT_GROUP_MEMBER   = 4;
	localparam logic [3:0]  SM_OFF            = 4'h0;
	localparam logic [3:0]  SM_CMP_LAST       = 4'h5;
	localparam logic [3:0]  SM_ACC_START      = 4'h8;
	localparam logic [3:0]  SM_ACC_END        = 4'h9;
	localparam logic [3:0]  SM_DEC_START      = 4'hA;
	localparam logic [3:0]  SM_DEC_END        = 4'hB;
	localparam logic [1:0]  SW_NOW            = 2'h0;
	localparam logic [1:0]  SW_GROUP          = 2'h1;
	localparam logic [1:0]  SW_SYNC           = 2'h2;
	localparam logic [1:0]  SW_STOPPED        = 2'h3;
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;
	typedef enum logic [2:0] {
		AX_IDLE = 3'b001,
		AX_WAIT = 3'b010,
		AX_RUN  = 3'b100
	} mss_ax_state_t;
endpackage : mss_pkg

// ### mss_axis_if.sv
// interface: per-axis control and status between the register file and one axis
`timescale 1ns/1ps
interface mss_axis_if;
	logic [4:0]  ctrl;
	logic [1:0]  start_wait_select;
	logic [3:0]  stop_wait_axis_mask;
	logic [3:0]  sync_mode;
	logic [1:0]  sync_src;
	logic        cmd_wr;
	logic        group_start;
	logic        group_stop;
	logic        sync_in;
	logic [3:0]  stopped_all;
	logic        line_stop;
	logic        fault;
	logic [5:0]  events;
	logic [7:0]  cmp_hit;
	logic        sync_pulse;
	logic        stopped;
	logic        moving;
	logic        decel;
	logic        abort;
	logic        stop_line_drive;
	logic        fault_stop;
	logic [1:0]  buf_count;
	logic        reg2_full;
	logic [2:0]  state;
	modport ctl (output ctrl, start_wait_select, stop_wait_axis_mask, sync_mode, sync_src, cmd_wr,
		group_start, group_stop, sync_in, stopped_all, line_stop, fault, events, cmp_hit,
		input sync_pulse, stopped, moving, decel, abort, stop_line_drive, fault_stop, buf_count,
		reg2_full, state);
	modport ax (input ctrl, start_wait_select, stop_wait_axis_mask, sync_mode, sync_src, cmd_wr,
		group_start, group_stop, sync_in, stopped_all, line_stop, fault, events, cmp_hit,
		output sync_pulse, stopped, moving, decel, abort, stop_line_drive, fault_stop, buf_count,
		reg2_full, state);
endinterface : mss_axis_if

// ### mss_axis.sv
// module: one axis of start hold, stop handling, sync pulse and pre-register tracking
`timescale 1ns/1ps
module mss_axis
	import mss_pkg::*;
(
	input  wire logic CLOCK_I,
	input  wire logic SYS_RST_I,
	mss_axis_if.ax    a
);
	mss_ax_state_t state_q;
	logic [1:0]    buf_q;
	logic          sync_q;
	logic          start_ok;
	logic          stop_req;
	logic          evt;
	logic          fault_stop_q;
	logic          mv_done;

	// ----------------------------------------
	// start condition
	// ----------------------------------------
	always_comb
	begin
		unique case (a.start_wait_select)
			SW_NOW:     start_ok = 1'b1;
			SW_GROUP:   start_ok = a.group_start;
			SW_SYNC:    start_ok = a.sync_in;
			SW_STOPPED: start_ok = ((a.stopped_all & a.stop_wait_axis_mask) == a.stop_wait_axis_mask);
		endcase
	end

	// group stop request reaches member axes; line stop only when enabled
	assign stop_req = (a.group_stop & a.ctrl[CT_GROUP_MEMBER])
		| (a.line_stop & a.ctrl[CT_STOP_ON_LINE]) | a.fault;

	// ----------------------------------------
	// command sequencing and pre-registers
	// ----------------------------------------
	assign mv_done = (state_q == AX_RUN) && a.events[5];

	// buffer count: 0 empty, 1 one held, 2 both pre-registers held; a third write
	// overwrites register two instead of growing, so count saturates at 2
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			state_q <= AX_IDLE;
			buf_q   <= 2'h0;
		end
		else
		begin
			unique case (state_q)
				AX_IDLE:
					if (buf_q != 2'h0)
						state_q <= AX_WAIT;
				AX_WAIT:
					if (stop_req)
						state_q <= AX_IDLE;
					else if (start_ok)
						state_q <= AX_RUN;
				AX_RUN:
					if (a.events[5] || stop_req)
						state_q <= (buf_q > 2'h1 && !stop_req) ? AX_WAIT : AX_IDLE;
				default:
					state_q <= AX_IDLE;
			endcase
			if (stop_req)
				buf_q <= 2'h0;
			else if (a.cmd_wr && !mv_done)
				buf_q <= (buf_q == 2'h2) ? 2'h2 : buf_q + 2'h1;
			else if (!a.cmd_wr && mv_done && buf_q != 2'h0)
				buf_q <= buf_q - 2'h1;
		end
	end

	// ----------------------------------------
	// internal sync pulse
	// ----------------------------------------
	always_comb
	begin
		evt = 1'b0;
		if (a.sync_mode != SM_OFF && a.sync_mode <= SM_CMP_LAST)
			evt = a.cmp_hit[a.sync_mode[2:0]];
		else if (a.sync_mode >= SM_ACC_START && a.sync_mode <= SM_DEC_END)
			evt = a.events[a.sync_mode[1:0]];
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			sync_q <= 1'b0;
		else
			sync_q <= evt & (state_q == AX_RUN);
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			fault_stop_q <= 1'b0;
		else
			// held while the abnormal input stays, so the shared line is not a one-clock glitch
			fault_stop_q <= a.fault & (fault_stop_q | (state_q == AX_RUN));
	end

	assign a.sync_pulse      = sync_q;
	assign a.stopped         = (state_q != AX_RUN);
	assign a.moving          = (state_q == AX_RUN);
	assign a.abort           = stop_req & (state_q == AX_RUN) & ~a.ctrl[CT_STOP_MODE];
	assign a.decel           = stop_req & (state_q == AX_RUN) & a.ctrl[CT_STOP_MODE];
	assign a.stop_line_drive = fault_stop_q & a.ctrl[CT_DRIVE_ON_FAULT];
	assign a.fault_stop      = fault_stop_q;
	assign a.buf_count       = buf_q;
	assign a.reg2_full       = (buf_q == 2'h2);
	assign a.state           = state_q;
endmodule : mss_axis

// ### mss_top.sv
// top: four-axis sync start/stop logic with an AXI4-Lite register slave
//
// Overview of operation
// - old version: status reports register two occupancy
// - new version: status encodes 0,1,2,3 occupancy
// - write into full register two overwrites it
// - group start/stop acts on all members together
// - start wait: now, group, sync, stops
// - start after all masked axes stopped
// - stop on group stop line when enabled
// - drive stop line on abnormal stop
// - stop mode 0 immediate, 1 decelerate
// - sync pulse source selectable axis 0-3
// - sync mode picks comparator or ramp event
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module mss_top
	import mss_pkg::*;
(
	input  wire logic        CLOCK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic [11:0] S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [11:0] S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	input  wire logic        GROUP_START_LINE_I,
	input  wire logic        GROUP_STOP_LINE_I,
	output logic             GROUP_STOP_LINE_O,
	output logic             GROUP_STOP_LINE_OE_N_O,
	input  wire logic [3:0]  SERVO_ALARM_I,
	input  wire logic [3:0]  END_LIMIT_I,
	input  wire logic [23:0] AXIS_EVENT_I,
	output logic [3:0]       AXIS_START_O,
	output logic [3:0]       AXIS_ABORT_O,
	output logic [3:0]       AXIS_DECEL_O,
	output logic [3:0]       SYNC_PULSE_O
);
	mss_axis_if ax_if [NUM_AXES] ();

	logic [4:0]  ctrl_q      [NUM_AXES];
	logic [1:0]  sws_q       [NUM_AXES];
	logic [3:0]  mask_q      [NUM_AXES];
	logic [3:0]  smode_q     [NUM_AXES];
	logic [1:0]  ssrc_q      [NUM_AXES];
	logic [3:0]  cmd_wr_q;
	logic        gstart_q;
	logic        gstop_q;
	logic [31:0] hw_ver_q;
	logic [3:0]  sync_vec;
	logic [3:0]  stop_vec;
	logic [3:0]  drive_vec;
	logic [3:0]  moving_q;
	logic [3:0]  moving_vec;
	logic [1:0]  bufc  [NUM_AXES];
	logic        r2f   [NUM_AXES];
	logic [2:0]  st    [NUM_AXES];
	logic        fstop [NUM_AXES];

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        do_write;
	logic [1:0]  wr_axis;
	logic [4:0]  wr_off;
	logic        wr_hit;

	assign S_AXI_AWREADY_O = ~aw_held_q & ~bvalid_q;
	assign S_AXI_WREADY_O  = ~w_held_q & ~bvalid_q;
	assign do_write        = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_axis         = awaddr_q[6:5];
	assign wr_off          = awaddr_q[4:0];
	assign wr_hit          = (awaddr_q == REG_GLOBAL) || (awaddr_q[11:7] == 5'h0 && awaddr_q[1:0] == 2'h0
		&& wr_off <= REG_BUF_STATUS[4:0]);

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA_I;
				wstrb_q  <= S_AXI_WSTRB_I;
			end
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && S_AXI_BREADY_I)
				bvalid_q <= 1'b0;
		end
	end

	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O  = bresp_q;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// narrow fields all sit in byte lane 0, so only strobe bit 0 matters
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			for (int i = 0; i < NUM_AXES; i++)
			begin
				ctrl_q[i]  <= 5'h00;
				sws_q[i]   <= SW_NOW;
				mask_q[i]  <= 4'h0;
				smode_q[i] <= SM_OFF;
				ssrc_q[i]  <= 2'h0;
			end
			cmd_wr_q <= 4'h0;
			gstart_q <= 1'b0;
			gstop_q  <= 1'b0;
			hw_ver_q <= HW_VERSION_RESET;
		end
		else
		begin
			cmd_wr_q <= 4'h0;
			gstart_q <= 1'b0;
			gstop_q  <= 1'b0;
			if (do_write && wr_hit && wstrb_q[0])
			begin
				if (awaddr_q == REG_GLOBAL)
				begin
					gstart_q <= wdata_q[GL_START_BIT];
					gstop_q  <= wdata_q[GL_STOP_BIT];
				end
				else
				begin
					unique case (wr_off)
						REG_CTRL[4:0]:     ctrl_q[wr_axis] <= wdata_q[4:0];
						REG_SYNC_OPT[4:0]:
						begin
							sws_q[wr_axis]  <= wdata_q[1:0];
							mask_q[wr_axis] <= wdata_q[7:4];
						end
						REG_SYNC_SIG[4:0]:
						begin
							smode_q[wr_axis] <= wdata_q[3:0];
							ssrc_q[wr_axis]  <= wdata_q[5:4];
						end
						REG_CMD[4:0]:      cmd_wr_q[wr_axis] <= 1'b1;
						default:           hw_ver_q <= hw_ver_q;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// axes and shared lines
	// ----------------------------------------
	// the line is open drain: drive low, otherwise release
	assign GROUP_STOP_LINE_O      = 1'b0;
	assign GROUP_STOP_LINE_OE_N_O = ~(|drive_vec);

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			moving_q <= 4'h0;
		else
			moving_q <= moving_vec;
	end

	for (genvar g = 0; g < NUM_AXES; g++)
	begin : g_axis
		assign ax_if[g].ctrl                = ctrl_q[g];
		assign ax_if[g].start_wait_select   = sws_q[g];
		assign ax_if[g].stop_wait_axis_mask = mask_q[g];
		assign ax_if[g].sync_mode           = smode_q[g];
		assign ax_if[g].sync_src            = ssrc_q[g];
		assign ax_if[g].cmd_wr              = cmd_wr_q[g];
		// one shared start for every member so all start on the same edge
		assign ax_if[g].group_start         = (gstart_q | GROUP_START_LINE_I) & ctrl_q[g][CT_GROUP_MEMBER];
		assign ax_if[g].group_stop          = gstop_q;
		assign ax_if[g].sync_in             = sync_vec[ssrc_q[g]];
		assign ax_if[g].stopped_all         = stop_vec;
		assign ax_if[g].line_stop           = GROUP_STOP_LINE_I;
		assign ax_if[g].fault               = SERVO_ALARM_I[g] | END_LIMIT_I[g];
		assign ax_if[g].events              = AXIS_EVENT_I[6*g +: 6];
		assign ax_if[g].cmp_hit             = {2'b00, AXIS_EVENT_I[6*g +: 5], 1'b0};
		assign sync_vec[g]   = ax_if[g].sync_pulse;
		assign stop_vec[g]   = ax_if[g].stopped;
		assign moving_vec[g] = ax_if[g].moving;
		assign drive_vec[g]  = ax_if[g].stop_line_drive;
		assign bufc[g]       = ax_if[g].buf_count;
		assign r2f[g]        = ax_if[g].reg2_full;
		assign st[g]         = ax_if[g].state;
		assign fstop[g]      = ax_if[g].fault_stop;
		assign AXIS_ABORT_O[g] = ax_if[g].abort;
		assign AXIS_DECEL_O[g] = ax_if[g].decel;

		mss_axis u_axis (
			.CLOCK_I   (CLOCK_I),
			.SYS_RST_I (SYS_RST_I),
			.a         (ax_if[g])
		);
	end

	assign AXIS_START_O = moving_vec & ~moving_q;
	assign SYNC_PULSE_O = sync_vec;

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic [1:0]  rd_axis;
	logic [1:0]  code;

	assign S_AXI_ARREADY_O = ~rvalid_q;
	assign rd_axis         = S_AXI_ARADDR_I[6:5];

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		code   = 2'h0;
		// 0 empty, 1 register in use (executing only), 2 reg one, 3 reg two
		unique case (bufc[rd_axis])
			2'h0: code = (st[rd_axis] == AX_RUN) ? 2'h1 : 2'h0;
			2'h1: code = 2'h2;
			default: code = 2'h3;
		endcase
		if (S_AXI_ARADDR_I == REG_GLOBAL)
			rd_val = hw_ver_q;
		else if (S_AXI_ARADDR_I[11:7] != 5'h0 || S_AXI_ARADDR_I[1:0] != 2'h0)
			rd_hit = 1'b0;
		else
		begin
			unique case (S_AXI_ARADDR_I[4:0])
				REG_CTRL[4:0]:       rd_val = {27'h0, ctrl_q[rd_axis]};
				REG_SYNC_OPT[4:0]:   rd_val = {24'h0, mask_q[rd_axis], 2'h0, sws_q[rd_axis]};
				REG_SYNC_SIG[4:0]:   rd_val = {26'h0, ssrc_q[rd_axis], smode_q[rd_axis]};
				REG_CMD[4:0]:        rd_val = 32'h0000_0000;
				REG_STATUS[4:0]:     rd_val = {25'h0, fstop[rd_axis], stop_vec[rd_axis], st[rd_axis], 2'h0};
				REG_BUF_STATUS[4:0]:
					if (hw_ver_q[HW_VER_BIT])
						rd_val = {30'h0, code};
					else
						rd_val = {31'h0, r2f[rd_axis]};
				default:             rd_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_hit ? rd_val : 32'h0000_0000;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_q && S_AXI_RREADY_I)
			rvalid_q <= 1'b0;
	end

	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O  = rdata_q;
	assign S_AXI_RRESP_O  = rresp_q;
endmodule : mss_top

// ### mss_chk.sv
// checker: port-level assertions for the multi-axis sync block
`timescale 1ns/1ps
module mss_chk
	import mss_pkg::*;
(
	input wire logic        CLOCK_I,
	input wire logic        SYS_RST_I,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic [1:0]  S_AXI_RRESP_O,
	input wire logic        GROUP_STOP_LINE_OE_N_O,
	input wire logic [3:0]  SERVO_ALARM_I,
	input wire logic [3:0]  END_LIMIT_I,
	input wire logic [23:0] AXIS_EVENT_I,
	input wire logic [3:0]  AXIS_START_O,
	input wire logic [3:0]  AXIS_ABORT_O,
	input wire logic [3:0]  AXIS_DECEL_O,
	input wire logic [3:0]  SYNC_PULSE_O
);
	logic [3:0] fault_in;
	assign fault_in = SERVO_ALARM_I | END_LIMIT_I;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	chk_bresp_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped");
	chk_rdata_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped");
	chk_err_data: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR |-> S_AXI_RDATA_O == 32'h0)
		else $error("refused read carries data");
	chk_start_single: assert property ((AXIS_START_O & $past(AXIS_START_O)) == 4'h0)
		else $error("start pulse too wide");
	chk_sync_single: assert property ((SYNC_PULSE_O & $past(SYNC_PULSE_O)) == 4'h0)
		else $error("sync pulse too wide");
	chk_sync_cause: assert property (SYNC_PULSE_O != 4'h0 |-> $past(AXIS_EVENT_I) != 24'h0)
		else $error("sync pulse without event");
	chk_stop_kind: assert property ((AXIS_ABORT_O & AXIS_DECEL_O) == 4'h0)
		else $error("abort and decel together");
	chk_fault_drive: assert property ($fell(GROUP_STOP_LINE_OE_N_O) |->
		($past(fault_in) | $past(fault_in, 2) | $past(fault_in, 3)) != 4'h0)
		else $error("stop line driven without fault");
endmodule : mss_chk

bind mss_top mss_chk i_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RREADY_I(S_AXI_RREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
	.GROUP_STOP_LINE_OE_N_O(GROUP_STOP_LINE_OE_N_O), .SERVO_ALARM_I(SERVO_ALARM_I), .END_LIMIT_I(END_LIMIT_I),
	.AXIS_EVENT_I(AXIS_EVENT_I), .AXIS_START_O(AXIS_START_O), .AXIS_ABORT_O(AXIS_ABORT_O),
	.AXIS_DECEL_O(AXIS_DECEL_O), .SYNC_PULSE_O(SYNC_PULSE_O));

// ### mss_card_model.sv
// model: other cards sharing the group start and stop lines
`timescale 1ns/1ps
module mss_card_model
(
	input  wire logic clk_i,
	input  wire logic oe_n_i,
	input  wire logic start_req_i,
	input  wire logic stop_req_i,
	output logic      start_line_o,
	output logic      stop_line_o
);
	logic start_q;
	logic stop_q;
	// a remote card reacts one clock after it is told, like the real logic
	always_ff @(posedge clk_i) start_q <= start_req_i;
	always_ff @(posedge clk_i) stop_q <= stop_req_i;
	// pulled-up wire: any card pulling low asserts stop to all cards
	assign stop_line_o = !oe_n_i || stop_q;
	assign start_line_o = start_q;
endmodule : mss_card_model

// ### testbench.sv
// testbench: register-level scenarios for the multi-axis sync block
`timescale 1ns/1ps
module testbench;
	import mss_pkg::*;
	logic        clk = 1'b0, rst = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, oe_n, start_line, stop_line;
	logic        start_req = 1'b0, stop_req = 1'b0;
	logic [1:0]  bresp, rresp, rresp_q;
	logic [3:0]  alarm = 4'h0, st, ab, dc, sp;
	logic [23:0] ev = 24'h0;
	int          cyc, t0, err_total, checks_done;
	int          st_cyc[4], ab_cyc[4], dc_cyc[4], sp_cyc[4];
	int          sm[10] = '{1, 2, 3, 4, 5, 8, 9, 10, 11, 0};
	int          sb[10] = '{0, 1, 2, 3, 4, 0, 1, 2, 3, 0};

	always #2 clk = ~clk;

	mss_top i_dut (
		.CLOCK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
		.GROUP_START_LINE_I(start_line), .GROUP_STOP_LINE_I(stop_line), .GROUP_STOP_LINE_O(),
		.GROUP_STOP_LINE_OE_N_O(oe_n), .SERVO_ALARM_I(alarm), .END_LIMIT_I(4'h0), .AXIS_EVENT_I(ev),
		.AXIS_START_O(st), .AXIS_ABORT_O(ab), .AXIS_DECEL_O(dc), .SYNC_PULSE_O(sp));
	mss_card_model i_card (.clk_i(clk), .oe_n_i(oe_n), .start_req_i(start_req), .stop_req_i(stop_req),
		.start_line_o(start_line), .stop_line_o(stop_line));

	// -------------------------------
	// pulse monitor: last cycle seen
	// -------------------------------
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		for (int a = 0; a < 4; a++)
		begin
			if (st[a] === 1'b1) st_cyc[a] <= cyc;
			if (ab[a] === 1'b1) ab_cyc[a] <= cyc;
			if (dc[a] === 1'b1) dc_cyc[a] <= cyc;
			if (sp[a] === 1'b1) sp_cyc[a] <= cyc;
		end
	end

	// -------------------------------
	// bus and helper tasks
	// -------------------------------
	// handshakes are judged mid-cycle so the edge that takes them is already known
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic tk_a, tk_w, vr, done;
		int   n;
		@(posedge clk);
		if (w)
		begin
			awaddr <= a;
			wdata <= d;
			{awvalid, wvalid} <= 2'b11;
		end
		else
		begin
			araddr <= a;
			arvalid <= 1'b1;
		end
		n = 0;
		do
		begin
			@(negedge clk);
			tk_a = (awvalid & awready) | (arvalid & arready);
			tk_w = wvalid & wready;
			vr = w ? bvalid : rvalid;
			done = vr & (w ? bready : rready);
			rd_q = rdata;
			rresp_q = w ? bresp : rresp;
			@(posedge clk);
			if (tk_a) {awvalid, arvalid} <= 2'b00;
			if (tk_w) wvalid <= 1'b0;
			if (w) bready <= vr & !done;
			else rready <= vr & !done;
			n++;
		end
		while (!done && n < 64);
		cmp("bus answer", 32'h1, 32'(done));
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		cmp("write resp", 32'(RESP_OKAY), 32'(rresp_q));
	endtask : wr

	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : cmp

	task automatic rdv(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0);
		cmp(s, e, rd_q & m);
	endtask : rdv

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic pulse_ev(input int a, input int b);
		@(posedge clk);
		ev[6 * a + b] <= 1'b1;
		@(posedge clk);
		ev <= 24'h0;
	endtask : pulse_ev

	function automatic logic [11:0] ax(input int a, input logic [11:0] off);
		return REG_AXIS_STRIDE * 12'(a) + off;
	endfunction : ax

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	initial
	begin
		tick(5000);
		err_total++;
		summarize;
	end

	// -------------------------------
	// scenarios
	// -------------------------------
	initial
	begin
		tick(5);
		rst <= 1'b0;
		rdv(REG_GLOBAL, 32'hFFFF_FFFF, HW_VERSION_RESET, "hwver");
		rdv(ax(0, REG_STATUS), 32'h1C, 32'h4, "idle");
		rdv(ax(0, REG_BUF_STATUS), 32'hFFFF_FFFF, 32'h0, "empty");
		rdv(12'h200, 32'h0, 32'h0, "unmapped");
		cmp("unmapped resp", 32'(RESP_SLVERR), 32'(rresp_q));
		$display("test 1 done");
		wr(ax(0, REG_CTRL), 32'h18);
		wr(ax(0, REG_SYNC_OPT), 32'(SW_GROUP));
		repeat (3) wr(ax(0, REG_CMD), 32'h1);
		rdv(ax(0, REG_BUF_STATUS), 32'hFFFF_FFFF, 32'h3, "two held");
		rdv(ax(0, REG_STATUS), 32'h1C, 32'h8, "waiting");
		wr(ax(1, REG_CTRL), 32'h14);
		wr(ax(1, REG_SYNC_OPT), 32'(SW_GROUP));
		wr(ax(1, REG_CMD), 32'h1);
		t0 = cyc;
		wr(REG_GLOBAL, 32'h1);
		tick(4);
		cmp("group start", 1, st_cyc[0] > t0);
		cmp("same instant", st_cyc[0], st_cyc[1]);
		t0 = cyc;
		wr(REG_GLOBAL, 32'h2);
		tick(4);
		cmp("abort", 1, ab_cyc[0] > t0);
		cmp("decel", 1, dc_cyc[1] > t0);
		cmp("no abort", 0, ab_cyc[1] > t0);
		rdv(ax(0, REG_BUF_STATUS), 32'hFFFF_FFFF, 32'h0, "cleared");
		wr(ax(0, REG_CTRL), 32'h10);
		$display("test 2 done");
		wr(ax(2, REG_CTRL), 32'h10);
		wr(ax(2, REG_SYNC_OPT), 32'(SW_GROUP));
		t0 = cyc;
		wr(ax(2, REG_CMD), 32'h1);
		tick(8);
		cmp("held", 0, st_cyc[2] > t0);
		@(posedge clk);
		start_req <= 1'b1;
		@(posedge clk);
		start_req <= 1'b0;
		tick(4);
		cmp("line start", 1, st_cyc[2] > t0);
		wr(ax(2, REG_CTRL), 32'h11);
		t0 = cyc;
		@(posedge clk);
		stop_req <= 1'b1;
		tick(2);
		stop_req <= 1'b0;
		tick(4);
		cmp("line stop", 1, ab_cyc[2] > t0);
		$display("test 3 done");
		wr(ax(3, REG_CTRL), 32'h2);
		t0 = cyc;
		wr(ax(3, REG_CMD), 32'h1);
		tick(3);
		cmp("start now", 1, st_cyc[3] > t0);
		alarm <= 4'h8;
		tick(5);
		cmp("line driven", 0, oe_n);
		rdv(ax(3, REG_STATUS), 32'h40, 32'h40, "fault flag");
		alarm <= 4'h0;
		wr(ax(3, REG_CTRL), 32'h0);
		tick(2);
		cmp("line freed", 1, oe_n);
		$display("test 4 done");
		wr(ax(0, REG_SYNC_OPT), 32'(SW_NOW));
		wr(ax(0, REG_CMD), 32'h1);
		wr(ax(1, REG_SYNC_OPT), 32'h13);
		t0 = cyc;
		wr(ax(1, REG_CMD), 32'h1);
		tick(8);
		cmp("wait stops", 0, st_cyc[1] > t0);
		pulse_ev(0, 5);
		tick(4);
		cmp("after stop", 1, st_cyc[1] > t0);
		pulse_ev(1, 5);
		$display("test 5 done");
		wr(ax(0, REG_CMD), 32'h1);
		for (int i = 0; i < 10; i++)
		begin
			wr(ax(0, REG_SYNC_SIG), 32'(sm[i]));
			t0 = cyc;
			pulse_ev(0, sb[i]);
			tick(3);
			cmp("sync mode", sm[i] != 0, sp_cyc[0] > t0);
		end
		wr(ax(3, REG_SYNC_OPT), 32'(SW_SYNC));
		wr(ax(2, REG_SYNC_OPT), 32'(SW_SYNC));
		wr(ax(2, REG_SYNC_SIG), 32'h10);
		wr(ax(3, REG_CMD), 32'h1);
		wr(ax(2, REG_CMD), 32'h1);
		wr(ax(0, REG_SYNC_SIG), 32'(SM_ACC_START));
		t0 = cyc;
		pulse_ev(0, 0);
		tick(4);
		cmp("sync start", 1, st_cyc[3] > t0);
		cmp("other src", 0, st_cyc[2] > t0);
		$display("test 6 done");
		summarize;
	end
endmodule : testbench
